// ### ssb_pkg.sv
// constants, register map and carrier types of the serial status and bit rate block
package ssb_pkg;
    // register indices on the plain register port
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_BIT_RATE = 4'h1;
    localparam logic [3:0] OFF_TX_DATA = 4'h2;
    localparam logic [3:0] OFF_RX_DATA = 4'h3;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'h5;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h6;

    // serial_status field positions
    localparam int TX_EMPTY_POS = 7;
    localparam int RX_FULL_POS = 6;
    localparam int PARITY_ERR_POS = 3;
    localparam int TX_END_POS = 2;
    localparam int RX_MP_POS = 1;
    localparam int TX_MP_POS = 0;

    // interrupt status / enable / clear field positions
    localparam int EV_RX_FULL = 0;
    localparam int EV_PARITY_ERR = 1;
    localparam int EV_TX_END = 2;
    localparam int EV_TX_EMPTY = 3;
    localparam int EV_COUNT = 4;

    // reset values
    localparam logic [7:0] BIT_RATE_RESET = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // timing: prescale step is four per clock select code, async oversampling
    localparam int PRESCALE_W = 6;
    localparam int OVERSAMPLE = 16;

    typedef struct packed {
        logic sync_mode;
        logic multiproc;
        logic parity_en;
        logic parity_odd;
        logic [1:0] clock_select;
    } ssb_mode_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_bit;
        logic mp_bit;
    } ssb_rx_ev_t;
endpackage : ssb_pkg

// ### ssb_core.sv
// status flags, bit rate divisor and bit rate generator of one serial channel
// How it works
// - parity mismatch on received character sets parity_error_flag
// - parity error loads data, receive_full_flag stays clear
// - parity error halts reception; synchronous also halts transmit
// - parity error clears on reset, standby, read-then-write-0
// - receive enable off keeps parity error
// - transmit end read-only, reads 1 after init
// - last bit with transmit empty sets transmit end
// - reset, standby, transmit disable force transmit end
// - transmit-empty clear or dma write clears transmit end
// - async multiprocessor receive captures bit, initially 0
// - receive enable off keeps captured multiprocessor bit
// - writable bit appended as transmitted multiprocessor bit
// - transmit multiprocessor bit ignored unless async, multiprocessor, busy
// - bit rate from divisor and selected prescaler
// - divisor always read/write, loads FF on init
// - each channel instance owns its generator
// - transmit load into shift register sets transmit empty
// - good reception sets receive_full_flag
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ssb_core #(
    parameter int OVERSAMPLE = ssb_pkg::OVERSAMPLE
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic standby,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire ssb_pkg::ssb_mode_t mode,
    input wire logic receive_enable,
    input wire logic transmit_enable,
    input wire ssb_pkg::ssb_rx_ev_t rx_ev,
    input wire logic tx_load,
    input wire logic tx_last_bit,
    input wire logic tx_active,
    input wire logic dma_tx_data_write,
    input wire logic [7:0] dma_tx_data,
    input wire logic dma_rx_data_read,
    output logic [7:0] transmit_data_reg,
    output logic [7:0] receive_data_reg,
    output logic transmit_empty_flag,
    output logic receive_full_flag,
    output logic parity_error_flag,
    output logic transmit_end_flag,
    output logic rx_multiproc_bit,
    output logic tx_multiproc_bit_out,
    output logic rx_hold,
    output logic tx_hold,
    output logic sample_tick,
    output logic bit_tick,
    output logic irq
);
    localparam int OS_W = $clog2(OVERSAMPLE);

    logic tx_empty_r, rx_full_r, par_err_r, tx_done_r, rx_mp_r, tx_mp_r;
    logic [2:0] arm_r;
    logic [7:0] divisor_r, tx_data_r, rx_data_r, rdata_r;
    logic [3:0] irq_stat_r, irq_en_r;
    logic [ssb_pkg::PRESCALE_W-1:0] pre_cnt_r;
    logic [7:0] div_r;
    logic [OS_W-1:0] os_r;

    // register port decode
    wire wr_status = reg_wr && reg_addr == ssb_pkg::OFF_STATUS;
    wire wr_divisor = reg_wr && reg_addr == ssb_pkg::OFF_BIT_RATE;
    wire wr_tx_data = reg_wr && reg_addr == ssb_pkg::OFF_TX_DATA;
    wire wr_iclr = reg_wr && reg_addr == ssb_pkg::OFF_IRQ_CLEAR;
    wire wr_ien = reg_wr && reg_addr == ssb_pkg::OFF_IRQ_ENABLE;
    wire rd_status = reg_rd && reg_addr == ssb_pkg::OFF_STATUS;

    wire [7:0] status_view = {tx_empty_r, rx_full_r, 2'b00, par_err_r, tx_done_r, rx_mp_r, tx_mp_r};

    wire [7:0] rd_mux =
        (reg_addr == ssb_pkg::OFF_STATUS) ? status_view :
        (reg_addr == ssb_pkg::OFF_BIT_RATE) ? divisor_r :
        (reg_addr == ssb_pkg::OFF_TX_DATA) ? tx_data_r :
        (reg_addr == ssb_pkg::OFF_RX_DATA) ? rx_data_r :
        (reg_addr == ssb_pkg::OFF_IRQ_STATUS) ? {4'h0, irq_stat_r} :
        (reg_addr == ssb_pkg::OFF_IRQ_ENABLE) ? {4'h0, irq_en_r} : 8'h00;

    // written-zero clears only count after the flag was read as one
    wire clr_par_err = wr_status && !reg_wdata[ssb_pkg::PARITY_ERR_POS] && arm_r[0];
    wire clr_rx_full = (wr_status && !reg_wdata[ssb_pkg::RX_FULL_POS] && arm_r[1]) ||
                       dma_rx_data_read;
    wire clr_tx_empty = (wr_status && !reg_wdata[ssb_pkg::TX_EMPTY_POS] && arm_r[2]) ||
                        dma_tx_data_write;

    // receive path
    wire rx_take = rx_ev.valid && receive_enable && !par_err_r;
    wire par_odd_count = ^rx_ev.data ^ rx_ev.parity_bit;
    wire par_bad = mode.parity_en && !mode.sync_mode &&
                   (par_odd_count != mode.parity_odd);
    wire set_par_err = rx_take && par_bad;
    wire rx_good = rx_take && !par_bad && !rx_full_r;
    wire load_rx_data = set_par_err || rx_good;
    wire cap_rx_mp = rx_take && mode.multiproc && !mode.sync_mode;

    // transmit path
    wire set_tx_done = tx_last_bit && tx_empty_r;

    // next values: set wins over any clear in the same cycle
    wire par_err_nxt = set_par_err || (par_err_r && !clr_par_err);
    wire rx_full_nxt = rx_good || (rx_full_r && !clr_rx_full);
    wire tx_empty_nxt = !transmit_enable || tx_load || (tx_empty_r && !clr_tx_empty);
    wire tx_done_nxt = !transmit_enable || set_tx_done || (tx_done_r && !clr_tx_empty);

    wire [3:0] ev_now = {tx_empty_nxt && !tx_empty_r, tx_done_nxt && !tx_done_r,
                         par_err_nxt && !par_err_r, rx_full_nxt && !rx_full_r};
    wire [3:0] irq_stat_nxt = ev_now | (irq_stat_r & ~(wr_iclr ? reg_wdata[3:0] : 4'h0));

    // read-arm: a status read that sees a flag at one enables its zero-write clear
    wire [2:0] flags3 = {tx_empty_r, rx_full_r, par_err_r};
    wire [2:0] arm_nxt = wr_status ? 3'b000 : (rd_status ? (arm_r | flags3) : arm_r) & flags3;

    always_ff @(posedge ref_clk) begin
        if (!reset_n || standby) begin
            par_err_r <= 1'b0;
            rx_full_r <= 1'b0;
            tx_empty_r <= 1'b1;
            tx_done_r <= 1'b1;
            arm_r <= 3'b000;
        end else begin
            par_err_r <= par_err_nxt;
            rx_full_r <= rx_full_nxt;
            tx_empty_r <= tx_empty_nxt;
            tx_done_r <= tx_done_nxt;
            arm_r <= arm_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n || standby) begin
            rx_mp_r <= 1'b0;
            tx_mp_r <= 1'b0;
            rx_data_r <= ssb_pkg::DATA_RESET;
            tx_data_r <= ssb_pkg::DATA_RESET;
            divisor_r <= ssb_pkg::BIT_RATE_RESET;
        end else begin
            if (cap_rx_mp) begin
                rx_mp_r <= rx_ev.mp_bit;
            end
            if (wr_status) begin
                tx_mp_r <= reg_wdata[ssb_pkg::TX_MP_POS];
            end
            if (load_rx_data) begin
                rx_data_r <= rx_ev.data;
            end
            if (dma_tx_data_write) begin
                tx_data_r <= dma_tx_data;
            end else if (wr_tx_data) begin
                tx_data_r <= reg_wdata;
            end
            if (wr_divisor) begin
                divisor_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_stat_r <= ssb_pkg::IRQ_RESET;
            irq_en_r <= ssb_pkg::IRQ_RESET;
            rdata_r <= 8'h00;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_ien) begin
                irq_en_r <= reg_wdata[3:0];
            end
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // bit rate generator, private to this channel instance
    wire [6:0] pre_span = 7'h01 << {mode.clock_select, 1'b0};
    wire [ssb_pkg::PRESCALE_W-1:0] pre_mask = ssb_pkg::PRESCALE_W'(pre_span - 7'h01);
    wire pre_tick = (pre_cnt_r & pre_mask) == '0;
    wire base_tick = pre_tick && div_r == 8'h00;
    wire os_last = os_r == OS_W'(OVERSAMPLE - 1);

    always_ff @(posedge ref_clk) begin
        if (!reset_n || standby) begin
            pre_cnt_r <= '0;
            div_r <= ssb_pkg::BIT_RATE_RESET;
            os_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
            if (pre_tick) begin
                div_r <= (div_r == 8'h00) ? divisor_r : div_r - 8'h01;
            end
            if (base_tick) begin
                os_r <= os_r + 1'b1;
            end
        end
    end

    assign sample_tick = base_tick;
    assign bit_tick = base_tick && (mode.sync_mode || os_last);

    // outputs
    assign reg_rdata = rdata_r;
    assign transmit_data_reg = tx_data_r;
    assign receive_data_reg = rx_data_r;
    assign transmit_empty_flag = tx_empty_r;
    assign receive_full_flag = rx_full_r;
    assign parity_error_flag = par_err_r;
    assign transmit_end_flag = tx_done_r;
    assign rx_multiproc_bit = rx_mp_r;
    assign tx_multiproc_bit_out = tx_mp_r && mode.multiproc && !mode.sync_mode && tx_active;
    assign rx_hold = par_err_r;
    assign tx_hold = par_err_r && mode.sync_mode;
    assign irq = |(irq_stat_r & irq_en_r);

    property p_par_err_set;
        @(posedge ref_clk) disable iff (!reset_n)
        (set_par_err && !standby) |=> parity_error_flag;
    endproperty
    a_par_err_set: assert property (p_par_err_set) else $error("parity error not flagged");

    property p_par_err_no_full;
        @(posedge ref_clk) disable iff (!reset_n)
        (set_par_err && !receive_full_flag && !standby) |=>
            !receive_full_flag && receive_data_reg == $past(rx_ev.data);
    endproperty
    a_par_err_no_full: assert property (p_par_err_no_full) else $error("parity error set full");

    property p_rx_refused;
        @(posedge ref_clk) disable iff (!reset_n)
        (parity_error_flag && !standby) |=> $stable(receive_data_reg);
    endproperty
    a_rx_refused: assert property (p_rx_refused) else $error("data taken under parity error");

    property p_par_err_clear;
        @(posedge ref_clk) disable iff (!reset_n)
        (clr_par_err && !set_par_err && !standby) |=> !parity_error_flag;
    endproperty
    a_par_err_clear: assert property (p_par_err_clear) else $error("parity error not cleared");

    property p_full_set;
        @(posedge ref_clk) disable iff (!reset_n)
        (rx_good && !standby) |=> receive_full_flag && receive_data_reg == $past(rx_ev.data);
    endproperty
    a_full_set: assert property (p_full_set) else $error("good character not flagged");

    property p_empty_set;
        @(posedge ref_clk) disable iff (!reset_n)
        (tx_load && !standby) |=> transmit_empty_flag;
    endproperty
    a_empty_set: assert property (p_empty_set) else $error("load did not set empty");

    property p_tx_done_ro;
        @(posedge ref_clk) disable iff (!reset_n)
        (wr_status && !set_tx_done && !clr_tx_empty && transmit_enable && !standby) |=>
            $stable(transmit_end_flag);
    endproperty
    a_tx_done_ro: assert property (p_tx_done_ro) else $error("status write moved end flag");

    property p_rx_mp_cap;
        @(posedge ref_clk) disable iff (!reset_n)
        (cap_rx_mp && !standby) |=> rx_multiproc_bit == $past(rx_ev.mp_bit);
    endproperty
    a_rx_mp_cap: assert property (p_rx_mp_cap) else $error("mp bit not captured");

    property p_rx_mp_keep;
        @(posedge ref_clk) disable iff (!reset_n)
        (!cap_rx_mp && !standby) |=> $stable(rx_multiproc_bit);
    endproperty
    a_rx_mp_keep: assert property (p_rx_mp_keep) else $error("mp bit changed unasked");

    property p_tx_done_clear;
        @(posedge ref_clk) disable iff (!reset_n)
        (clr_tx_empty && !set_tx_done && transmit_enable && !standby) |=> !transmit_end_flag;
    endproperty
    a_tx_done_clear: assert property (p_tx_done_clear) else $error("end flag not cleared");

    property p_divisor_write;
        @(posedge ref_clk) disable iff (!reset_n)
        (wr_divisor && !standby) |=> divisor_r == $past(reg_wdata);
    endproperty
    a_divisor_write: assert property (p_divisor_write) else $error("divisor write lost");

    property p_reload;
        @(posedge ref_clk) disable iff (!reset_n)
        (base_tick && !standby) |=> div_r == $past(divisor_r);
    endproperty
    a_reload: assert property (p_reload) else $error("generator did not reload");

    property p_bit_sync;
        @(posedge ref_clk) disable iff (!reset_n)
        mode.sync_mode |-> bit_tick == sample_tick;
    endproperty
    a_bit_sync: assert property (p_bit_sync) else $error("sync bit tick wrong");

    property p_inhibit;
        @(posedge ref_clk) disable iff (!reset_n)
        parity_error_flag |-> rx_hold && (tx_hold == mode.sync_mode);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit wrong under parity error");

    property p_standby_init;
        @(posedge ref_clk) disable iff (!reset_n)
        standby |=> !parity_error_flag && transmit_end_flag && transmit_empty_flag;
    endproperty
    a_standby_init: assert property (p_standby_init) else $error("standby init wrong");

    property p_rx_off_keep;
        @(posedge ref_clk) disable iff (!reset_n)
        ($fell(receive_enable) && !standby && !wr_status) |=>
            parity_error_flag == $past(parity_error_flag);
    endproperty
    a_rx_off_keep: assert property (p_rx_off_keep) else $error("receive off changed parity flag");

    property p_tx_done_set;
        @(posedge ref_clk) disable iff (!reset_n)
        (tx_last_bit && transmit_empty_flag) |=> transmit_end_flag;
    endproperty
    a_tx_done_set: assert property (p_tx_done_set) else $error("transmit end not set");

    property p_tx_off_force;
        @(posedge ref_clk) disable iff (!reset_n)
        !transmit_enable |=> transmit_end_flag && transmit_empty_flag;
    endproperty
    a_tx_off_force: assert property (p_tx_off_force) else $error("transmit off not forcing end");

    property p_tx_done_dma;
        @(posedge ref_clk) disable iff (!reset_n)
        (dma_tx_data_write && transmit_enable && !tx_last_bit && !standby) |=> !transmit_end_flag;
    endproperty
    a_tx_done_dma: assert property (p_tx_done_dma) else $error("dma write kept transmit end");

    property p_tx_mp_gate;
        @(posedge ref_clk) disable iff (!reset_n)
        tx_multiproc_bit_out |-> mode.multiproc && !mode.sync_mode && tx_active;
    endproperty
    a_tx_mp_gate: assert property (p_tx_mp_gate) else $error("mp bit sent when ignored");

    property p_divisor_init;
        @(posedge ref_clk) disable iff (!reset_n)
        standby |=> divisor_r == ssb_pkg::BIT_RATE_RESET;
    endproperty
    a_divisor_init: assert property (p_divisor_init) else $error("divisor not FF after standby");
endmodule : ssb_core
`default_nettype wire

// ### ssb_far_end.sv
// far-end transceiver model: hands received characters to the channel
`timescale 1ns/100ps
`default_nettype none
module ssb_far_end (
    input wire logic ref_clk,
    output var ssb_pkg::ssb_rx_ev_t rx_ev
);
    initial rx_ev = '0;
    // one character per pulse, even parity unless told to break it
    task automatic send(input logic [7:0] d, input logic bad, input logic mp);
        @(posedge ref_clk);
        rx_ev <= '{1'b1, d, (^d) ^ bad, mp};
        @(posedge ref_clk);
        // released lines show the inverse of the last value
        rx_ev <= '{1'b0, ~d, ~((^d) ^ bad), ~mp};
    endtask : send
endmodule : ssb_far_end
`default_nettype wire

// ### ssb_core_tb.sv
// self-checking bench of the status flags and bit rate divisor
`timescale 1ns/100ps
`default_nettype none
module ssb_core_tb;
    localparam logic [3:0] ST = ssb_pkg::OFF_STATUS;
    localparam logic [3:0] BR = ssb_pkg::OFF_BIT_RATE;
    localparam logic [3:0] IE = ssb_pkg::OFF_IRQ_ENABLE;
    localparam logic [3:0] IC = ssb_pkg::OFF_IRQ_CLEAR;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic standby = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, txd, rxd;
    ssb_pkg::ssb_mode_t mode = 6'h18;
    ssb_pkg::ssb_rx_ev_t rx_ev;
    logic rx_en = 1'b1;
    logic tx_en = 1'b1;
    logic tx_load = 1'b0;
    logic tx_last = 1'b0;
    logic tx_active = 1'b0;
    logic dma_wr = 1'b0;
    logic end_f, mp_out, rx_hold, tx_hold, smp, irq;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    ssb_core i_ssb_core (.ref_clk(ref_clk), .reset_n(reset_n), .standby(standby),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mode(mode), .receive_enable(rx_en),
        .transmit_enable(tx_en), .rx_ev(rx_ev), .tx_load(tx_load), .tx_last_bit(tx_last),
        .tx_active(tx_active), .dma_tx_data_write(dma_wr), .dma_tx_data(8'h5A),
        .dma_rx_data_read(1'b0), .transmit_data_reg(txd), .receive_data_reg(rxd),
        .transmit_empty_flag(), .receive_full_flag(), .parity_error_flag(),
        .transmit_end_flag(end_f), .rx_multiproc_bit(), .tx_multiproc_bit_out(mp_out),
        .rx_hold(rx_hold), .tx_hold(tx_hold), .sample_tick(smp), .bit_tick(), .irq(irq));
    ssb_far_end i_ssb_far_end (.ref_clk(ref_clk), .rx_ev(rx_ev));
    always #10 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cb(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : cb
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg read", e, reg_rdata);
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic period(input logic [7:0] e);
        int n;
        n = 0;
        @(posedge ref_clk iff smp);
        do begin
            @(posedge ref_clk);
            n++;
        end while (!smp && n < 2000);
        chk("sample period", e, n[7:0]);
    endtask : period
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(ST, 8'h84);
        rd(BR, 8'hFF);
        rd(4'hF, 8'h00);
        wr(BR, 8'h02);
        rd(BR, 8'h02);
        period(8'h03);
        mode.clock_select <= 2'h1;
        period(8'h0C);
        wr(IE, 8'h01);
        i_ssb_far_end.send(8'hA5, 1'b0, 1'b1);
        #1 chk("rx data", 8'hA5, rxd);
        cb("irq", 1'b1, irq);
        rd(ST, 8'hC6);
        wr(ST, 8'h80);
        wr(IC, 8'h01);
        #1 cb("irq", 1'b0, irq);
        i_ssb_far_end.send(8'h3C, 1'b1, 1'b0);
        #1 chk("rx data", 8'h3C, rxd);
        cb("rx hold", 1'b1, rx_hold);
        cb("tx hold", 1'b0, tx_hold);
        i_ssb_far_end.send(8'h11, 1'b0, 1'b1);
        #1 chk("rx data", 8'h3C, rxd);
        rx_en <= 1'b0;
        rd(ST, 8'h8C);
        mode.sync_mode <= 1'b1;
        #21 cb("tx hold", 1'b1, tx_hold);
        mode.sync_mode <= 1'b0;
        wr(ST, 8'h88);
        wr(ST, 8'h80);
        rd(ST, 8'h8C);
        wr(ST, 8'h80);
        rd(ST, 8'h84);
        rx_en <= 1'b1;
        wr(ST, 8'h81);
        tx_active <= 1'b1;
        #21 cb("tx mp", 1'b1, mp_out);
        mode.sync_mode <= 1'b1;
        #20 cb("tx mp", 1'b0, mp_out);
        mode.sync_mode <= 1'b0;
        tx_active <= 1'b0;
        #20 cb("tx mp", 1'b0, mp_out);
        rd(ST, 8'h85);
        wr(ST, 8'h01);
        rd(ST, 8'h01);
        @(posedge ref_clk) tx_load <= 1'b1;
        @(posedge ref_clk) tx_load <= 1'b0;
        rd(ST, 8'h81);
        @(posedge ref_clk) tx_last <= 1'b1;
        @(posedge ref_clk) tx_last <= 1'b0;
        rd(ST, 8'h85);
        @(posedge ref_clk) dma_wr <= 1'b1;
        @(posedge ref_clk) dma_wr <= 1'b0;
        #1 cb("tx end", 1'b0, end_f);
        chk("tx data", 8'h5A, txd);
        @(posedge ref_clk) tx_en <= 1'b0;
        @(posedge ref_clk) tx_en <= 1'b1;
        #1 cb("tx end", 1'b1, end_f);
        wr(ST, 8'h80);
        #1 cb("tx end", 1'b1, end_f);
        @(posedge ref_clk) standby <= 1'b1;
        @(posedge ref_clk) standby <= 1'b0;
        rd(BR, 8'hFF);
        rd(ST, 8'h84);
        complete_run();
    end
endmodule : ssb_core_tb
`default_nettype wire
